// ### design/link_wakeup_cfg.svh
`ifndef LINK_WAKEUP_CFG_SVH
`define LINK_WAKEUP_CFG_SVH

// Register offsets in the main bank
`define ADDR_CLIENT_TIMER_EN 7'h01
`define ADDR_RETRY_GUARD_ERR 7'h02
`define ADDR_PAIR_OSC_RETX 7'h03
`define ADDR_FUSE_WAKE_TIMING 7'h04

// Writable bit masks; reserved bits stay zero
`define MASK_CLIENT_TIMER_EN 8'hff
`define MASK_RETRY_GUARD_ERR 8'he7
`define MASK_PAIR_OSC_RETX 8'h53
`define MASK_FUSE_WAKE_TIMING 8'hbf

// Reset values
`define RST_CLIENT_TIMER_EN 8'h00
`define RST_RETRY_GUARD_ERR 8'h00
`define RST_PAIR_OSC_RETX 8'h00
`define RST_FUSE_WAKE_TIMING 8'h00

// Field positions
`define GUARD_MSB 7
`define GUARD_LSB 5
`define ERRLIM_MSB 2
`define ERRLIM_LSB 0
`define LONGSCAN_BIT 6
`define HFOSC_BIT 4
`define RETXLIM_MSB 1
`define RETXLIM_LSB 0
`define FUSEEN_BIT 7
`define LONGWAKE_BIT 5
`define WAKECYC_MSB 4
`define WAKECYC_LSB 2
`define WAKECALL_MSB 1
`define WAKECALL_LSB 0

// Timing
`define CLK_FREQ_KHZ 50000
`define PAIR_TIME_MS 1000
`define WAKE_UNIT_US 500
`define WAKE_RX_BASE_UNITS 15'h007d
`define WAKE_TX_BASE_UNITS 15'h00fa

`endif

// ### design/link_wakeup_config_regs.sv
// Function
// - In master role each bit of the client timer enable byte enables the timer of that client.
// - In client role only bit 0 of that byte counts, enabling the single client timer.
// - Bits 7 to 5 of byte 0x02 give the master guard time used in retransmit operation.
// - The error limit field bounds the error counter: zero ignores errors, N allows N errors.
// - With extended pairing clear, pairing lasts one second.
// - With extended pairing set, pairing lasts as long as the bit stays one.
// - Clearing extended pairing ends pairing at once, even before one second.
// - Bit 4 of byte 0x03 forces the high-frequency oscillator on, for fuse programming.
// - In master role the retransmit limit allows zero to three retransmits after a nack.
// - Bit 7 of byte 0x04 enables fuse programming mode.
// - With extended wake transmit clear, the wake call lasts the selected duration.
// - With extended wake transmit set, the wake call lasts while the bit stays one.
// - The wake cycle field sets the receiver poll interval, 62.5 ms doubling to 8000 ms.
// - The wake call field sets the call length, 125, 250, 500 or 1000 ms.
`timescale 1ns/10ps
`include "link_wakeup_cfg.svh"
module link_wakeup_config_regs #(
   parameter int PAIR_CYCLES = `PAIR_TIME_MS * `CLK_FREQ_KHZ,
   parameter int UNIT_CYCLES = (`WAKE_UNIT_US * `CLK_FREQ_KHZ) / 1000
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port from the host serial port decoder
   input wire logic bank_shadow_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Role and mode from neighbouring registers
   input wire logic master_role_i,
   input wire logic nack_retransmit_mode_i,
   input wire logic wake_rx_en_i,
   // Link manager events
   input wire logic comm_error_i,
   input wire logic comm_ok_i,
   input wire logic nack_i,
   input wire logic ack_i,
   input wire logic pair_start_i,
   input wire logic wake_call_start_i,
   // Configuration outputs
   output logic [7:0] client_timer_en_o,
   output logic [2:0] guard_time_o,
   output logic hf_osc_force_on_o,
   output logic fuse_mode_o,
   // Status and event outputs
   output logic err_limit_hit_o,
   output logic retransmit_o,
   output logic give_up_o,
   output logic pairing_active_o,
   output logic wake_tx_on_o,
   output logic wake_rx_poll_o
);

   localparam int PAIR_W = $clog2(PAIR_CYCLES + 1);
   localparam int UNIT_W = $clog2(UNIT_CYCLES + 1);
   localparam logic [PAIR_W-1:0] PAIR_LAST = PAIR_W'(PAIR_CYCLES - 1);
   localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);

   // Power-of-two interval in half-millisecond units
   function automatic logic [14:0] wake_units(input logic [14:0] base, input logic [2:0] code);
      wake_units = base << code;
   endfunction : wake_units

   logic [7:0] timer_en_q;
   logic [7:0] rge_q;
   logic [7:0] pox_q;
   logic [7:0] fwt_q;
   logic [7:0] rdata_q;

   // Address decode, main bank only
   wire main_bank_w = ~bank_shadow_i;
   wire sel_te_w = main_bank_w && (reg_addr_i == `ADDR_CLIENT_TIMER_EN);
   wire sel_rge_w = main_bank_w && (reg_addr_i == `ADDR_RETRY_GUARD_ERR);
   wire sel_pox_w = main_bank_w && (reg_addr_i == `ADDR_PAIR_OSC_RETX);
   wire sel_fwt_w = main_bank_w && (reg_addr_i == `ADDR_FUSE_WAKE_TIMING);

   // Read mux; unmapped and shadow addresses give zero
   logic [7:0] rd_mux_w;
   always_comb begin
      if (sel_te_w) begin
         rd_mux_w = timer_en_q;
      end else if (sel_rge_w) begin
         rd_mux_w = rge_q;
      end else if (sel_pox_w) begin
         rd_mux_w = pox_q;
      end else if (sel_fwt_w) begin
         rd_mux_w = fwt_q;
      end else begin
         rd_mux_w = 8'h00;
      end
   end

   // Register writes, reserved bits masked off
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timer_en_q <= `RST_CLIENT_TIMER_EN;
         rge_q <= `RST_RETRY_GUARD_ERR;
         pox_q <= `RST_PAIR_OSC_RETX;
         fwt_q <= `RST_FUSE_WAKE_TIMING;
         rdata_q <= 8'h00;
      end else begin
         if (reg_wr_i && sel_te_w) timer_en_q <= reg_wdata_i & `MASK_CLIENT_TIMER_EN;
         if (reg_wr_i && sel_rge_w) rge_q <= reg_wdata_i & `MASK_RETRY_GUARD_ERR;
         if (reg_wr_i && sel_pox_w) pox_q <= reg_wdata_i & `MASK_PAIR_OSC_RETX;
         if (reg_wr_i && sel_fwt_w) fwt_q <= reg_wdata_i & `MASK_FUSE_WAKE_TIMING;
         if (reg_rd_i) rdata_q <= rd_mux_w;
      end
   end

   // Field extraction
   wire [2:0] guard_w = rge_q[`GUARD_MSB:`GUARD_LSB];
   wire [2:0] err_lim_w = rge_q[`ERRLIM_MSB:`ERRLIM_LSB];
   wire longscan_w = pox_q[`LONGSCAN_BIT];
   wire [1:0] retx_lim_w = pox_q[`RETXLIM_MSB:`RETXLIM_LSB];
   wire longwake_w = fwt_q[`LONGWAKE_BIT];
   wire [2:0] wake_cyc_w = fwt_q[`WAKECYC_MSB:`WAKECYC_LSB];
   wire [2:0] wake_call_w = {1'b0, fwt_q[`WAKECALL_MSB:`WAKECALL_LSB]};

   // Client role sees only the first timer
   wire [7:0] timer_en_w = master_role_i ? timer_en_q : {7'h00, timer_en_q[0]};

   // Error counter saturates one past the largest limit
   logic [3:0] err_cnt_q;
   logic [3:0] err_cnt_d;
   always_comb begin
      err_cnt_d = err_cnt_q;
      if (comm_ok_i) begin
         err_cnt_d = 4'h0;
      end else if (comm_error_i && (err_cnt_q != 4'h8)) begin
         err_cnt_d = err_cnt_q + 4'h1;
      end
   end
   wire err_hit_w = (err_lim_w != 3'h0) && (err_cnt_q > {1'b0, err_lim_w});

   // Retransmit budget per packet; client role never retries
   logic [1:0] retx_cnt_q;
   logic [1:0] retx_cnt_d;
   logic retx_d;
   logic give_up_d;
   wire retx_ok_w = master_role_i && nack_retransmit_mode_i && (retx_cnt_q < retx_lim_w);
   always_comb begin
      retx_cnt_d = retx_cnt_q;
      retx_d = 1'b0;
      give_up_d = 1'b0;
      if (ack_i) begin
         retx_cnt_d = 2'h0;
      end else if (nack_i) begin
         if (retx_ok_w) begin
            retx_cnt_d = retx_cnt_q + 2'h1;
            retx_d = 1'b1;
         end else begin
            retx_cnt_d = 2'h0;
            give_up_d = 1'b1;
         end
      end
   end

   // Pairing window: fixed second or held by the extended bit
   link_wakeup_pkg::pair_state_e pair_q;
   link_wakeup_pkg::pair_state_e pair_d;
   logic [PAIR_W-1:0] pair_cnt_q;
   logic [PAIR_W-1:0] pair_cnt_d;
   always_comb begin
      pair_d = pair_q;
      pair_cnt_d = pair_cnt_q;
      case (pair_q)
         link_wakeup_pkg::PAIR_IDLE: begin
            pair_cnt_d = '0;
            if (pair_start_i) begin
               pair_d = longscan_w ? link_wakeup_pkg::PAIR_HELD : link_wakeup_pkg::PAIR_TIMED;
            end
         end
         link_wakeup_pkg::PAIR_TIMED: begin
            pair_cnt_d = pair_cnt_q + PAIR_W'(1);
            if (longscan_w) begin
               pair_d = link_wakeup_pkg::PAIR_HELD;
            end else if (pair_cnt_q == PAIR_LAST) begin
               pair_d = link_wakeup_pkg::PAIR_IDLE;
            end
         end
         link_wakeup_pkg::PAIR_HELD: begin
            // Falling bit ends at once, whatever time has passed
            if (!longscan_w) begin
               pair_d = link_wakeup_pkg::PAIR_IDLE;
            end
         end
         default: begin
            pair_d = link_wakeup_pkg::PAIR_IDLE;
         end
      endcase
   end

   // Half-millisecond tick for the free-running receiver poll
   logic [UNIT_W-1:0] unit_cnt_q;
   wire unit_tick_w = (unit_cnt_q == UNIT_LAST);

   // Wake call state
   link_wakeup_pkg::wake_tx_state_e wtx_q;
   link_wakeup_pkg::wake_tx_state_e wtx_d;
   logic wtx_elapsed_q;
   logic wtx_elapsed_d;
   logic tx_done_w;
   always_comb begin
      wtx_d = wtx_q;
      wtx_elapsed_d = wtx_elapsed_q;
      case (wtx_q)
         link_wakeup_pkg::WTX_IDLE: begin
            wtx_elapsed_d = 1'b0;
            if (wake_call_start_i) begin
               wtx_d = link_wakeup_pkg::WTX_ON;
            end
         end
         link_wakeup_pkg::WTX_ON: begin
            if (tx_done_w) begin
               wtx_elapsed_d = 1'b1;
            end
            // Extended bit keeps the call going past its set time
            if (!longwake_w && (tx_done_w || wtx_elapsed_q)) begin
               wtx_d = link_wakeup_pkg::WTX_IDLE;
            end
         end
         default: begin
            wtx_d = link_wakeup_pkg::WTX_IDLE;
         end
      endcase
   end

   // Call prescaler starts with the call; a shared tick could cut up to one unit off
   logic [UNIT_W-1:0] tx_unit_q;
   wire tx_idle_w = (wtx_q == link_wakeup_pkg::WTX_IDLE);
   wire tx_tick_w = (tx_unit_q == UNIT_LAST);

   // Call duration timer, restarted at each call start
   wake_interval_timer u_tx_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .restart_i(tx_idle_w),
      .run_i(1'b1),
      .tick_i(tx_tick_w),
      .period_i(wake_units(`WAKE_TX_BASE_UNITS, wake_call_w)),
      .done_o(tx_done_w)
   );

   // Receiver poll interval, free running while enabled
   logic rx_done_w;
   wake_interval_timer u_rx_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .restart_i(~wake_rx_en_i),
      .run_i(1'b1),
      .tick_i(unit_tick_w),
      .period_i(wake_units(`WAKE_RX_BASE_UNITS, wake_cyc_w)),
      .done_o(rx_done_w)
   );

   // State and counters
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         err_cnt_q <= 4'h0;
         retx_cnt_q <= 2'h0;
         pair_q <= link_wakeup_pkg::PAIR_IDLE;
         pair_cnt_q <= '0;
         unit_cnt_q <= '0;
         tx_unit_q <= '0;
         wtx_q <= link_wakeup_pkg::WTX_IDLE;
         wtx_elapsed_q <= 1'b0;
      end else begin
         err_cnt_q <= err_cnt_d;
         retx_cnt_q <= retx_cnt_d;
         pair_q <= pair_d;
         pair_cnt_q <= pair_cnt_d;
         unit_cnt_q <= unit_tick_w ? '0 : unit_cnt_q + UNIT_W'(1);
         tx_unit_q <= (tx_tick_w || tx_idle_w) ? '0 : tx_unit_q + UNIT_W'(1);
         wtx_q <= wtx_d;
         wtx_elapsed_q <= wtx_elapsed_d;
      end
   end

   // Registered outputs, one cycle behind their sources
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         client_timer_en_o <= 8'h00;
         guard_time_o <= 3'h0;
         hf_osc_force_on_o <= 1'b0;
         fuse_mode_o <= 1'b0;
         err_limit_hit_o <= 1'b0;
         retransmit_o <= 1'b0;
         give_up_o <= 1'b0;
         pairing_active_o <= 1'b0;
         wake_tx_on_o <= 1'b0;
         wake_rx_poll_o <= 1'b0;
      end else begin
         client_timer_en_o <= timer_en_w;
         guard_time_o <= guard_w;
         hf_osc_force_on_o <= pox_q[`HFOSC_BIT];
         fuse_mode_o <= fwt_q[`FUSEEN_BIT];
         err_limit_hit_o <= err_hit_w;
         retransmit_o <= retx_d;
         give_up_o <= give_up_d;
         pairing_active_o <= (pair_d != link_wakeup_pkg::PAIR_IDLE);
         wake_tx_on_o <= (wtx_d == link_wakeup_pkg::WTX_ON);
         wake_rx_poll_o <= rx_done_w && wake_rx_en_i;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule : link_wakeup_config_regs

// ### design/link_wakeup_pkg.sv
package link_wakeup_pkg;

   typedef enum logic [1:0] {
      PAIR_IDLE = 2'b00,
      PAIR_TIMED = 2'b01,
      PAIR_HELD = 2'b10
   } pair_state_e;

   typedef enum logic [1:0] {
      WTX_IDLE = 2'b00,
      WTX_ON = 2'b01
   } wake_tx_state_e;

endpackage : link_wakeup_pkg

// ### design/wake_interval_timer.sv
`timescale 1ns/10ps
module wake_interval_timer (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control
   input wire logic restart_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [14:0] period_i,
   // Expiry pulse
   output logic done_o
);
   logic [14:0] cnt_q;
   logic [14:0] cnt_d;
   logic done_d;
   logic done_q;
   wire last_w = (cnt_q >= (period_i - 15'h0001));

   // Periodic count in half-millisecond units
   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (restart_i) begin
         cnt_d = 15'h0000;
      end else if (run_i && tick_i) begin
         if (last_w) begin
            cnt_d = 15'h0000;
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 15'h0001;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= 15'h0000;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
endmodule : wake_interval_timer

// ### testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic mclk_i,
   // Register port towards the device
   output logic bank_shadow_o,
   output logic [6:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   // Idle, main bank selected
   initial begin
      bank_shadow_o = 1'b0;
      reg_addr_o = 7'h7f;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h5a;
   end

   // One-cycle strobe; address and data scrambled after, never left stale
   task automatic access(input logic shadow, input logic wr, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge mclk_i);
      bank_shadow_o = shadow;
      reg_addr_o = a;
      reg_wr_o = wr;
      reg_rd_o = !wr;
      reg_wdata_o = d;
      @(negedge mclk_i);
      q = reg_rdata_i;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      bank_shadow_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask : access
endmodule : host_model

// ### testbench/link_wakeup_config_regs_assertions.sv
`timescale 1ns/10ps
`include "link_wakeup_cfg.svh"
module link_wakeup_config_regs_assertions #(
   parameter int PAIR_CYCLES = 20,
   parameter int UNIT_CYCLES = 4
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port and events
   input wire logic bank_shadow_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic master_role_i,
   input wire logic nack_i,
   input wire logic ack_i,
   // Outputs under watch
   input wire logic [7:0] client_timer_en_o,
   input wire logic [2:0] guard_time_o,
   input wire logic hf_osc_force_on_o,
   input wire logic fuse_mode_o,
   input wire logic err_limit_hit_o,
   input wire logic retransmit_o,
   input wire logic give_up_o,
   input wire logic pairing_active_o,
   input wire logic wake_tx_on_o
);
   // Write decode, main bank only
   logic wr_main;
   logic w2;
   logic w3;
   logic w4;
   logic longscan_q;
   logic [2:0] errlim_q;
   assign wr_main = reg_wr_i && !bank_shadow_i;
   assign w2 = wr_main && reg_addr_i == `ADDR_RETRY_GUARD_ERR;
   assign w3 = wr_main && reg_addr_i == `ADDR_PAIR_OSC_RETX;
   assign w4 = wr_main && reg_addr_i == `ADDR_FUSE_WAKE_TIMING;

   // Own copy of fields, so checks do not lean on the design's registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         longscan_q <= 1'b0;
         errlim_q <= 3'h0;
      end else begin
         longscan_q <= w3 ? reg_wdata_i[6] : longscan_q;
         errlim_q <= w2 ? reg_wdata_i[2:0] : errlim_q;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   guard_map_a: assert property (w2 |-> ##2 guard_time_o == $past(reg_wdata_i[7:5], 2))
      else $error("guard time differs from written field");
   hfosc_map_a: assert property (w3 |-> ##2 hf_osc_force_on_o == $past(reg_wdata_i[4], 2))
      else $error("oscillator force differs from written bit");
   fuse_map_a: assert property (w4 |-> ##2 fuse_mode_o == $past(reg_wdata_i[7], 2))
      else $error("fuse mode differs from written bit");
   client_bits_a: assert property (
      !master_role_i && !$past(master_role_i) |-> client_timer_en_o[7:1] == 7'h00)
      else $error("upper client timers enabled in client role");
   nack_answer_a: assert property (nack_i && !ack_i |=> retransmit_o != give_up_o)
      else $error("nack not answered by exactly one of retry or give up");
   errlim_zero_a: assert property (
      errlim_q == 3'h0 && $past(errlim_q) == 3'h0 |-> !err_limit_hit_o)
      else $error("error limit hit with errors ignored");
   scan_end_a: assert property ($fell(longscan_q) |-> ##[0:2] !pairing_active_o)
      else $error("pairing kept after extended pairing cleared");
   scan_hold_a: assert property (longscan_q && pairing_active_o |=> pairing_active_o)
      else $error("pairing ended while extended pairing set");

   // Main scenarios reached
   pair_end_c: cover property ($fell(pairing_active_o));
   give_up_c: cover property (give_up_o);
   wake_c: cover property ($fell(wake_tx_on_o));
endmodule : link_wakeup_config_regs_assertions

bind link_wakeup_config_regs link_wakeup_config_regs_assertions #(
   .PAIR_CYCLES(PAIR_CYCLES),
   .UNIT_CYCLES(UNIT_CYCLES)
) chk_u (
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .bank_shadow_i(bank_shadow_i),
   .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i),
   .master_role_i(master_role_i),
   .nack_i(nack_i),
   .ack_i(ack_i),
   .client_timer_en_o(client_timer_en_o),
   .guard_time_o(guard_time_o),
   .hf_osc_force_on_o(hf_osc_force_on_o),
   .fuse_mode_o(fuse_mode_o),
   .err_limit_hit_o(err_limit_hit_o),
   .retransmit_o(retransmit_o),
   .give_up_o(give_up_o),
   .pairing_active_o(pairing_active_o),
   .wake_tx_on_o(wake_tx_on_o)
);

// ### testbench/link_wakeup_config_regs_tb.sv
`timescale 1ns/10ps
module link_wakeup_config_regs_tb;
   logic mclk_i, rst_i, bank_shadow_i, reg_wr_i, reg_rd_i;
   logic [6:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, client_timer_en_o;
   logic [2:0] guard_time_o;
   logic master_role_i, nack_retransmit_mode_i, wake_rx_en_i, comm_error_i, comm_ok_i;
   logic nack_i, ack_i, pair_start_i, wake_call_start_i, hf_osc_force_on_o, fuse_mode_o;
   logic err_limit_hit_o, retransmit_o, give_up_o, pairing_active_o, wake_tx_on_o;
   logic wake_rx_poll_o;
   int mismatches = 0;
   int compares = 0;
   int n;

   link_wakeup_config_regs #(.PAIR_CYCLES(20), .UNIT_CYCLES(4)) dut_u (.*);
   host_model host_u (.mclk_i(mclk_i), .bank_shadow_o(bank_shadow_i),
      .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

   // 50 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Counts are bench integers, so a window check is enough
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   // Extra edge so registered field outputs have settled
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_u.access(1'b0, 1'b1, a, d, q);
      @(negedge mclk_i);
   endtask : wr

   task automatic pulse(ref logic s);
      @(negedge mclk_i);
      s = 1'b1;
      @(negedge mclk_i);
      s = 1'b0;
   endtask : pulse

   task automatic send_nack(input logic retry);
      pulse(nack_i);
      chk("retransmit_o", {7'h0, retry}, {7'h0, retransmit_o});
      chk("give_up_o", {7'h0, !retry}, {7'h0, give_up_o});
   endtask : send_nack

   // Hit shows two edges after the error pulse
   task automatic send_err(input logic hit);
      pulse(comm_error_i);
      repeat (2) @(negedge mclk_i);
      chk("err_limit_hit_o", {7'h0, hit}, {7'h0, err_limit_hit_o});
   endtask : send_err

   task automatic measure(input logic tx, output int k);
      k = 0;
      while ((tx ? wake_tx_on_o : pairing_active_o) === 1'b1 && k < 20000) begin
         @(negedge mclk_i);
         k++;
      end
   endtask : measure

   task automatic rx_gap(output int k);
      k = 0;
      do begin
         @(negedge mclk_i);
         k++;
      end while (wake_rx_poll_o !== 1'b1 && k < 20000);
   endtask : rx_gap

   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] m [1:5] = '{8'hff, 8'he7, 8'h53, 8'hbf, 8'h00};
      for (int a = 1; a <= 5; a++) begin
         host_u.access(1'b0, 1'b0, a[6:0], 8'h00, d);
         chk("reset value", 8'h00, d);
         wr(a[6:0], 8'hff);
         host_u.access(1'b0, 1'b0, a[6:0], 8'h00, d);
         chk("read back", m[a], d);
      end
      chk("guard_time_o", 8'h07, {5'h0, guard_time_o});
      chk("hf_osc_force_on_o", 8'h01, {7'h0, hf_osc_force_on_o});
      chk("fuse_mode_o", 8'h01, {7'h0, fuse_mode_o});
      host_u.access(1'b1, 1'b1, 7'h02, 8'h00, d);
      @(negedge mclk_i);
      chk("shadow write", 8'h07, {5'h0, guard_time_o});
      host_u.access(1'b1, 1'b0, 7'h02, 8'h00, d);
      chk("shadow read", 8'h00, d);
      host_u.access(1'b0, 1'b0, 7'h02, 8'h00, d);
      chk("main after shadow", 8'he7, d);
      wr(7'h02, 8'h40);
      chk("guard_time_o", 8'h02, {5'h0, guard_time_o});
      wr(7'h03, 8'h00);
      wr(7'h04, 8'h00);
      chk("fuse_mode_o off", 8'h00, {7'h0, fuse_mode_o});
   endtask : t_regs

   task automatic t_role();
      master_role_i = 1'b1;
      wr(7'h01, 8'ha5);
      chk("client_timer_en_o", 8'ha5, client_timer_en_o);
      wr(7'h01, 8'hff);
      chk("client_timer_en_o", 8'hff, client_timer_en_o);
      master_role_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("client_timer_en_o", 8'h01, client_timer_en_o);
      wr(7'h01, 8'h00);
      chk("client_timer_en_o", 8'h00, client_timer_en_o);
   endtask : t_role

   task automatic t_err_retx();
      wr(7'h02, 8'h01);
      send_err(1'b0);
      send_err(1'b1);
      pulse(comm_ok_i);
      wr(7'h02, 8'h00);
      repeat (3) send_err(1'b0);
      master_role_i = 1'b1;
      nack_retransmit_mode_i = 1'b1;
      wr(7'h03, 8'h03);
      repeat (3) send_nack(1'b1);
      send_nack(1'b0);
      wr(7'h03, 8'h01);
      send_nack(1'b1);
      pulse(ack_i);
      send_nack(1'b1);
      wr(7'h03, 8'h00);
      send_nack(1'b0);
      master_role_i = 1'b0;
      wr(7'h03, 8'h03);
      send_nack(1'b0);
   endtask : t_err_retx

   task automatic t_pair_wake();
      wr(7'h03, 8'h00);
      pulse(pair_start_i);
      measure(1'b0, n);
      chk_rng("pairing length", 20, 21, n);
      wr(7'h03, 8'h40);
      pulse(pair_start_i);
      repeat (30) @(negedge mclk_i);
      chk("pairing held", 8'h01, {7'h0, pairing_active_o});
      wr(7'h03, 8'h00);
      chk("pairing stopped", 8'h00, {7'h0, pairing_active_o});
      wr(7'h03, 8'h40);
      pulse(pair_start_i);
      repeat (5) @(negedge mclk_i);
      wr(7'h03, 8'h00);
      chk("pairing cut short", 8'h00, {7'h0, pairing_active_o});
      for (int c = 0; c < 2; c++) begin
         wr(7'h04, c[7:0]);
         pulse(wake_call_start_i);
         measure(1'b1, n);
         chk_rng("wake call length", 1000 << c, (1000 << c) + 3, n);
      end
      wr(7'h04, 8'h20);
      pulse(wake_call_start_i);
      repeat (1500) @(negedge mclk_i);
      chk("wake call held", 8'h01, {7'h0, wake_tx_on_o});
      wr(7'h04, 8'h00);
      repeat (3) @(negedge mclk_i);
      chk("wake call ended", 8'h00, {7'h0, wake_tx_on_o});
      wake_rx_en_i = 1'b1;
      for (int c = 0; c < 2; c++) begin
         wr(7'h04, {3'h0, c[2:0], 2'h0});
         repeat (2) rx_gap(n);
         chk_rng("poll interval", 500 << c, 500 << c, n);
      end
   endtask : t_pair_wake

   task automatic finish_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // Watchdog, well beyond the expected 8k cycles
   initial begin
      repeat (50000) @(posedge mclk_i);
      mismatches++;
      finish_test();
   end

   initial begin
      rst_i = 1'b1;
      {master_role_i, nack_retransmit_mode_i, wake_rx_en_i, comm_error_i} = 4'h0;
      {comm_ok_i, nack_i, ack_i, pair_start_i, wake_call_start_i} = 5'h00;
      repeat (6) @(negedge mclk_i);
      rst_i = 1'b0;
      t_regs();
      t_role();
      t_err_retx();
      t_pair_wake();
      finish_test();
   end
endmodule : link_wakeup_config_regs_tb
